// file: hw/pmbus_page_pkg.sv
package pmbus_page_pkg;
	// command codes of the locally held words and of the forwarded commands the logic decodes
	localparam logic [7:0] CMD_PAGE = 8'h00;
	localparam logic [7:0] CMD_OPERATION = 8'h01;
	localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;
	localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
	localparam logic [7:0] CMD_AUX_HOST_COMMAND = 8'hc8;
	localparam logic [7:0] CMD_AUX_HOST0_DATA = 8'hc9;
	localparam logic [7:0] CMD_AUX_HOST1_DATA = 8'hca;
	localparam logic [7:0] CMD_GLOBAL_PAGE_MASK = 8'he4;
	localparam logic [7:0] CMD_BUS_BASE_ADDRESS = 8'he6;
	// page selector values
	localparam logic [7:0] PAGE_CHAN0 = 8'h00;
	localparam logic [7:0] PAGE_CHAN1 = 8'h01;
	localparam logic [7:0] PAGE_GLOBAL = 8'hff;
	// reset values
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [7:0] WRITE_PROTECT_RESET = 8'h00;
	localparam logic [1:0] GLOBAL_MASK_RESET = 2'h3;
	localparam logic [6:0] BASE_ADDRESS_RESET = 7'h5c;
	localparam logic [15:0] AUX_WORD_RESET = 16'h0000;
	// write protect encodings
	localparam logic [7:0] WP_LEVEL1 = 8'h80;
	localparam logic [7:0] WP_LEVEL2 = 8'h40;
	// field layout
	localparam int MASK_CHAN0_BIT = 0;
	localparam int MASK_CHAN1_BIT = 1;
	localparam int BASE_ADDR_WIDTH = 7;
	localparam logic [3:0] ADDR_OFFSET_MAX = 4'h8;
	// data formats
	localparam logic [1:0] FMT_REGISTER = 2'h0;
	localparam logic [1:0] FMT_LINEAR_5_11 = 2'h1;
	localparam logic [1:0] FMT_LINEAR_16U = 2'h2;
	localparam int L11_EXP_MSB = 15;
	localparam int L11_EXP_LSB = 11;
	localparam int L11_MANT_MSB = 10;
	localparam logic signed [4:0] L16_EXPONENT = -5'sd13;
	// answer to a paged read on the global page
	localparam logic [15:0] UNDEFINED_READ = 16'hffff;
endpackage

// file: hw/linear_format_decode.sv
`timescale 1ns/10ps
module linear_format_decode
	import pmbus_page_pkg::*;
(
	input wire logic [15:0] raw_word,
	input wire logic [1:0] format_sel,
	output logic signed [16:0] mantissa,
	output logic signed [4:0] exponent
);
	always_comb begin
		mantissa = 17'sd0;
		exponent = 5'sd0;
		if (format_sel == FMT_LINEAR_5_11) begin
			mantissa = 17'(signed'(raw_word[L11_MANT_MSB:0]));
			exponent = signed'(raw_word[L11_EXP_MSB:L11_EXP_LSB]);
		end else if (format_sel == FMT_LINEAR_16U) begin
			mantissa = signed'({1'b0, raw_word});
			exponent = L16_EXPONENT;
		end else begin
			mantissa = signed'({1'b0, raw_word});
			exponent = 5'sd0;
		end
	end
endmodule

// file: hw/pmbus_page_addressing.sv
`timescale 1ns/10ps
// Notes on behaviour
// - page 0x00 steers paged commands to channel 0, 0x01 to channel 1.
// - global page writes reach every channel whose mask bit is set, together.
// - only clear faults, operation and on/off config accept the global page.
// - paged read on global page returns junk and raises the communication fault.
// - unsupported paged write on global page is dropped and raises the fault.
// - other page values are reserved; host avoids them, device gives no meaning.
// - 5+11 linear: signed 11-bit mantissa low, signed 5-bit exponent high.
// - 16-bit unsigned linear: unsigned mantissa, fixed exponent of minus 13.
// - register format carries 16 or 8 raw bits defined per command.
// - write protect byte: not paged, read/write, resets 0x00, storable.
// - global page mask byte: not paged, read/write, resets 0x03, storable.
// - one shared read/write command word for all auxiliary hosts.
// - separate read/write data words for auxiliary host 0 and host 1.
// - mask bit 0 gates channel 0, bit 1 channel 1; clear means ignore.
// - bus address is base address plus select offset 0 to 8.
// - 0x80 blocks all but few writes; 0x40 selects looser level 2.
module pmbus_page_addressing
	import pmbus_page_pkg::*;
#(
	parameter logic [7:0] STORAGE_UNLOCK_CODE = 8'hbd,
	parameter logic [7:0] CLEAR_ENERGY_CODE = 8'hbe,
	parameter logic [7:0] PG_GPO_CODE = 8'hbf
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_paged,
	input wire logic [1:0] cmd_format,
	input wire logic [15:0] chan0_rdata,
	input wire logic [15:0] chan1_rdata,
	input wire logic [15:0] common_rdata,
	input wire logic write_protect_pin,
	input wire logic address_select_high_input,
	input wire logic address_select_low_input,
	input wire logic [3:0] address_offset,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic [1:0] chan_cmd_valid,
	output logic common_cmd_valid,
	output logic chan_cmd_write,
	output logic [7:0] chan_cmd_code,
	output logic [15:0] chan_cmd_wdata,
	output logic signed [16:0] value_mantissa,
	output logic signed [4:0] value_exponent,
	output logic cml_fault,
	output logic [7:0] page_select,
	output logic [7:0] write_protect_level,
	output logic [1:0] global_page_channel_mask,
	output logic [6:0] bus_address
);
	import pmbus_page_pkg::*;

	logic [7:0] channel_page_select;
	logic [7:0] wp_level;
	logic [15:0] aux_host_command_word;
	logic [15:0] aux_host0_data_word;
	logic [15:0] aux_host1_data_word;
	logic [1:0] page_mask;
	logic [6:0] bus_base_address;
	logic [7:0] next_page;
	logic [7:0] next_wp;
	logic [15:0] next_aux_cmd;
	logic [15:0] next_aux0;
	logic [15:0] next_aux1;
	logic [1:0] next_mask;
	logic [6:0] next_base;
	logic next_cml;
	logic next_rsp_valid;
	logic [15:0] next_rsp_data;
	logic [1:0] next_chan_valid;
	logic next_common_valid;
	logic [6:0] next_bus_address;
	logic signed [16:0] dec_mantissa;
	logic signed [4:0] dec_exponent;
	logic local_cmd;
	logic global_ok;
	logic level1;
	logic level2;
	logic wp_exempt;
	logic blocked;
	logic do_write;
	logic cml_set;
	logic cml_clear;
	logic [3:0] sel_offset;

	linear_format_decode u_decode (
		.raw_word(cmd_wdata),
		.format_sel(cmd_format),
		.mantissa(dec_mantissa),
		.exponent(dec_exponent)
	);

	always_comb begin
		local_cmd = (cmd_code == CMD_PAGE) || (cmd_code == CMD_WRITE_PROTECT) ||
			(cmd_code == CMD_AUX_HOST_COMMAND) || (cmd_code == CMD_AUX_HOST0_DATA) ||
			(cmd_code == CMD_AUX_HOST1_DATA) || (cmd_code == CMD_GLOBAL_PAGE_MASK) ||
			(cmd_code == CMD_BUS_BASE_ADDRESS);
		global_ok = (cmd_code == CMD_CLEAR_FAULTS) || (cmd_code == CMD_OPERATION) ||
			(cmd_code == CMD_ON_OFF_CONFIG);
		// strictest of pin and register wins
		level1 = (wp_level == WP_LEVEL1);
		level2 = !level1 && ((wp_level == WP_LEVEL2) || write_protect_pin);
		wp_exempt = (cmd_code == CMD_WRITE_PROTECT) || (cmd_code == CMD_PAGE) ||
			(cmd_code == STORAGE_UNLOCK_CODE) || (cmd_code == CMD_STORE_USER_ALL) ||
			(cmd_code == CMD_AUX_HOST_COMMAND);
		blocked = 1'b0;
		if (level1) begin
			blocked = !wp_exempt;
		end else if (level2) begin
			blocked = !(wp_exempt || (cmd_code == CMD_OPERATION) ||
				(cmd_code == CMD_GLOBAL_PAGE_MASK) || (cmd_code == CLEAR_ENERGY_CODE) ||
				(cmd_code == PG_GPO_CODE) || (cmd_code == CMD_CLEAR_FAULTS));
		end
		do_write = cmd_valid && cmd_write && !blocked;
		sel_offset = {address_select_high_input, address_select_low_input, 2'b00} |
			address_offset;
		if (sel_offset > ADDR_OFFSET_MAX) begin
			sel_offset = ADDR_OFFSET_MAX;
		end
	end

	always_comb begin
		next_page = channel_page_select;
		next_wp = wp_level;
		next_aux_cmd = aux_host_command_word;
		next_aux0 = aux_host0_data_word;
		next_aux1 = aux_host1_data_word;
		next_mask = page_mask;
		next_base = bus_base_address;
		next_rsp_valid = cmd_valid && !cmd_write;
		next_rsp_data = 16'h0000;
		next_chan_valid = 2'b00;
		next_common_valid = 1'b0;
		cml_set = 1'b0;
		cml_clear = 1'b0;
		if (cmd_valid && local_cmd) begin
			if (cmd_write) begin
				if (do_write) begin
					if (cmd_code == CMD_PAGE) begin
						next_page = cmd_wdata[7:0];
					end else if (cmd_code == CMD_WRITE_PROTECT) begin
						next_wp = cmd_wdata[7:0];
					end else if (cmd_code == CMD_AUX_HOST_COMMAND) begin
						next_aux_cmd = cmd_wdata;
					end else if (cmd_code == CMD_AUX_HOST0_DATA) begin
						next_aux0 = cmd_wdata;
					end else if (cmd_code == CMD_AUX_HOST1_DATA) begin
						next_aux1 = cmd_wdata;
					end else if (cmd_code == CMD_GLOBAL_PAGE_MASK) begin
						next_mask = cmd_wdata[1:0];
					end else begin
						next_base = cmd_wdata[6:0];
					end
				end
			end else begin
				// 8-bit words sit low, upper bits zero
				if (cmd_code == CMD_PAGE) begin
					next_rsp_data = {8'h00, channel_page_select};
				end else if (cmd_code == CMD_WRITE_PROTECT) begin
					next_rsp_data = {8'h00, wp_level};
				end else if (cmd_code == CMD_AUX_HOST_COMMAND) begin
					next_rsp_data = aux_host_command_word;
				end else if (cmd_code == CMD_AUX_HOST0_DATA) begin
					next_rsp_data = aux_host0_data_word;
				end else if (cmd_code == CMD_AUX_HOST1_DATA) begin
					next_rsp_data = aux_host1_data_word;
				end else if (cmd_code == CMD_GLOBAL_PAGE_MASK) begin
					next_rsp_data = {14'h0000, page_mask};
				end else begin
					next_rsp_data = {9'h000, bus_base_address};
				end
			end
		end else if (cmd_valid && cmd_paged) begin
			if (channel_page_select == PAGE_CHAN0) begin
				next_chan_valid = {1'b0, cmd_write ? do_write : 1'b1};
				next_rsp_data = chan0_rdata;
			end else if (channel_page_select == PAGE_CHAN1) begin
				next_chan_valid = {cmd_write ? do_write : 1'b1, 1'b0};
				next_rsp_data = chan1_rdata;
			end else if (channel_page_select == PAGE_GLOBAL) begin
				if (!cmd_write) begin
					next_rsp_data = UNDEFINED_READ;
					cml_set = 1'b1;
				end else if (!global_ok) begin
					cml_set = 1'b1;
				end else if (do_write) begin
					next_chan_valid = page_mask;
				end
			end
			// reserved page values reach no channel and read as zero
		end else if (cmd_valid) begin
			next_common_valid = cmd_write ? do_write : 1'b1;
			next_rsp_data = common_rdata;
		end
		if (do_write && (cmd_code == CMD_CLEAR_FAULTS)) begin
			cml_clear = 1'b1;
		end
		// a new fault outweighs a clear in the same cycle
		next_cml = cml_set || (cml_fault && !cml_clear);
		next_bus_address = 7'(bus_base_address + {3'b000, sel_offset});
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			channel_page_select <= PAGE_RESET;
			wp_level <= WRITE_PROTECT_RESET;
			aux_host_command_word <= AUX_WORD_RESET;
			aux_host0_data_word <= AUX_WORD_RESET;
			aux_host1_data_word <= AUX_WORD_RESET;
			page_mask <= GLOBAL_MASK_RESET;
			bus_base_address <= BASE_ADDRESS_RESET;
			cml_fault <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
			chan_cmd_valid <= 2'b00;
			common_cmd_valid <= 1'b0;
			chan_cmd_write <= 1'b0;
			chan_cmd_code <= 8'h00;
			chan_cmd_wdata <= 16'h0000;
			value_mantissa <= 17'sd0;
			value_exponent <= 5'sd0;
			bus_address <= BASE_ADDRESS_RESET;
		end else begin
			channel_page_select <= next_page;
			wp_level <= next_wp;
			aux_host_command_word <= next_aux_cmd;
			aux_host0_data_word <= next_aux0;
			aux_host1_data_word <= next_aux1;
			page_mask <= next_mask;
			bus_base_address <= next_base;
			cml_fault <= next_cml;
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
			chan_cmd_valid <= next_chan_valid;
			common_cmd_valid <= next_common_valid;
			chan_cmd_write <= cmd_valid && cmd_write;
			chan_cmd_code <= cmd_code;
			chan_cmd_wdata <= cmd_wdata;
			value_mantissa <= dec_mantissa;
			value_exponent <= dec_exponent;
			bus_address <= next_bus_address;
		end
	end

	// stored copies for nonvolatile save
	assign page_select = channel_page_select;
	assign write_protect_level = wp_level;
	assign global_page_channel_mask = page_mask;

	a_chan0_route: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && !local_cmd && cmd_paged && !cmd_write &&
		channel_page_select == PAGE_CHAN0
		|=> chan_cmd_valid == 2'b01 && rsp_data == $past(chan0_rdata))
		else $error("page 0 read not routed to channel 0");
	a_global_write: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && cmd_write && cmd_paged && !local_cmd && global_ok && !blocked &&
		channel_page_select == PAGE_GLOBAL
		|=> chan_cmd_valid == $past(page_mask))
		else $error("global write did not follow the mask");
	a_global_only: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && cmd_paged && !local_cmd && !global_ok &&
		channel_page_select == PAGE_GLOBAL
		|=> chan_cmd_valid == 2'b00 && cml_fault)
		else $error("unsupported global command reached a channel");
	a_global_read: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && !cmd_write && cmd_paged && !local_cmd &&
		channel_page_select == PAGE_GLOBAL
		|=> rsp_valid && rsp_data == UNDEFINED_READ && cml_fault)
		else $error("global paged read gave no fault");
	a_cml_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		cml_fault && !(cmd_valid && cmd_write && cmd_code == CMD_CLEAR_FAULTS)
		|=> cml_fault)
		else $error("communication fault dropped without a clear");
	a_l16_exponent: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_format == FMT_LINEAR_16U
		|=> value_exponent == -5'sd13 && value_mantissa >= 17'sd0)
		else $error("unsigned linear decode wrong");
	a_l11_fields: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_format == FMT_LINEAR_5_11
		|=> value_exponent == $signed($past(cmd_wdata[15:11])) &&
		value_mantissa[10:0] == $past(cmd_wdata[10:0]))
		else $error("5+11 linear decode wrong");
	a_level1_block: assert property (@(posedge clk) disable iff (!rst_n)
		wp_level == WP_LEVEL1 && cmd_valid && cmd_write &&
		cmd_code == CMD_GLOBAL_PAGE_MASK
		|=> $stable(page_mask))
		else $error("level 1 protection let a write through");
	a_address_sum: assert property (@(posedge clk) disable iff (!rst_n)
		$stable(bus_base_address) && $stable(sel_offset)
		|=> bus_address == 7'($past(bus_base_address) + $past(sel_offset)))
		else $error("bus address is not base plus offset");
	a_page_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!(cmd_valid && cmd_write && cmd_code == CMD_PAGE)
		|=> $stable(channel_page_select))
		else $error("page selector changed without a write");
endmodule

// file: bench/pmbus_host_model.sv
`timescale 1ns/10ps
module pmbus_host_model (
	input wire logic clk,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	output logic cmd_paged,
	output logic [1:0] cmd_format
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
		cmd_paged = 1'b0;
		cmd_format = 2'h0;
	end
	// one command, held across the taking edge, then released
	task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d,
		input logic p, input logic [1:0] f);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code = c;
		cmd_wdata = d;
		cmd_paged = p;
		cmd_format = f;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_code = ~c;
		cmd_wdata = ~d;
	endtask
endmodule

// file: bench/pmbus_page_addressing_tb_top.sv
`timescale 1ns/10ps
module pmbus_page_addressing_tb_top;
	import pmbus_page_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid, cmd_write, cmd_paged, rsp_valid, common_cmd_valid, chan_cmd_write, cml_fault;
	logic [7:0] cmd_code, chan_cmd_code, page_select, write_protect_level, code;
	logic [15:0] cmd_wdata, rsp_data, chan_cmd_wdata, chan0_rdata, chan1_rdata, common_rdata;
	logic [1:0] cmd_format, chan_cmd_valid, global_page_channel_mask, f;
	logic signed [16:0] value_mantissa;
	logic signed [4:0] value_exponent;
	logic [6:0] bus_address;
	logic wp_pin, sel_h, sel_l;
	logic [3:0] offs;
	logic [31:0] seed = 32'h8024;
	logic [7:0] gcode [3] = '{CMD_OPERATION, CMD_ON_OFF_CONFIG, CMD_CLEAR_FAULTS};
	logic [15:0] aux [3];
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	pmbus_host_model i_pmbus_host_model (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_paged(cmd_paged),
		.cmd_format(cmd_format));
	pmbus_page_addressing i_pmbus_page_addressing (.clk(clk), .rst_n(rst_n),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .cmd_paged(cmd_paged), .cmd_format(cmd_format),
		.chan0_rdata(chan0_rdata), .chan1_rdata(chan1_rdata), .common_rdata(common_rdata),
		.write_protect_pin(wp_pin), .address_select_high_input(sel_h),
		.address_select_low_input(sel_l), .address_offset(offs), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .chan_cmd_valid(chan_cmd_valid), .common_cmd_valid(common_cmd_valid),
		.chan_cmd_write(chan_cmd_write), .chan_cmd_code(chan_cmd_code),
		.chan_cmd_wdata(chan_cmd_wdata), .value_mantissa(value_mantissa),
		.value_exponent(value_exponent), .cml_fault(cml_fault), .page_select(page_select),
		.write_protect_level(write_protect_level),
		.global_page_channel_mask(global_page_channel_mask), .bus_address(bus_address));
	always #10 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [6:0] exp_addr(input logic [6:0] b, input logic h, input logic l,
		input logic [3:0] o);
		logic [3:0] n;
		n = {h, l, 2'b00} | o;
		if (n > 4'h8) n = 4'h8;
		return b + {3'h0, n};
	endfunction
	function automatic logic signed [16:0] exp_mant(input logic [1:0] fm, input logic [15:0] w);
		return (fm == 2'h1) ? {{6{w[10]}}, w[10:0]} : {1'b0, w};
	endfunction
	function automatic logic signed [4:0] exp_exp(input logic [1:0] fm, input logic [15:0] w);
		// 5'h13 is minus 13 in five bits
		return (fm == 2'h1) ? w[15:11] : ((fm == 2'h2) ? 5'h13 : 5'h00);
	endfunction
	task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic p);
		i_pmbus_host_model.send(1'b1, c, d, p, 2'h0);
	endtask
	task automatic rd(input logic [7:0] c, input logic p);
		i_pmbus_host_model.send(1'b0, c, 16'h0000, p, 2'h0);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		{wp_pin, sel_h, sel_l, offs} = 7'h00;
		{chan0_rdata, chan1_rdata, common_rdata} = {16'h1111, 16'h2222, 16'h3c3c};
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("page", 8'h00, page_select);
		chk("wp", 8'h00, write_protect_level);
		chk("mask", 2'h3, global_page_channel_mask);
		chk("addr", 7'h5c, bus_address);
		rd(CMD_PAGE, 1'b0);
		chk("rsp_valid", 1'b1, rsp_valid);
		chk("page rd", 16'h0000, rsp_data);
		rd(8'h30, 1'b0);
		chk("common rd", 16'h3c3c, rsp_data);
		chk("common valid", 1'b1, common_cmd_valid);
		// channel selected before each programming write; reserved pages never used
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			f = (seed[6:5] == 2'h3) ? 2'h0 : seed[6:5];
			code = {4'h2, seed[4:1]};
			wr(CMD_PAGE, {15'h0000, seed[0]}, 1'b0);
			i_pmbus_host_model.send(1'b1, code, seed[31:16], 1'b1, f);
			chk("chan valid", seed[0] ? 2'h2 : 2'h1, chan_cmd_valid);
			chk("chan write", 1'b1, chan_cmd_write);
			chk("chan code", code, chan_cmd_code);
			chk("chan data", seed[31:16], chan_cmd_wdata);
			chk("mant", exp_mant(f, seed[31:16]), value_mantissa);
			chk("exp", exp_exp(f, seed[31:16]), value_exponent);
			rd(code, 1'b1);
			chk("chan rd valid", seed[0] ? 2'h2 : 2'h1, chan_cmd_valid);
			chk("chan rd", seed[0] ? 16'h2222 : 16'h1111, rsp_data);
			rd(CMD_PAGE, 1'b0);
			chk("page rd", {15'h0000, seed[0]}, rsp_data);
		end
		for (int m = 3; m >= 0; m--) begin
			wr(CMD_GLOBAL_PAGE_MASK, m[15:0], 1'b0);
			chk("mask", m[1:0], global_page_channel_mask);
			wr(CMD_PAGE, 16'h00ff, 1'b0);
			for (int k = 0; k < 3; k++) begin
				wr(gcode[k], 16'h0055, 1'b1);
				chk("global valid", m[1:0], chan_cmd_valid);
			end
			wr(8'h21, 16'h1234, 1'b1);
			chk("drop", 2'h0, chan_cmd_valid);
			chk("cml wr", 1'b1, cml_fault);
			wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
			chk("cml clr", 1'b0, cml_fault);
			rd(8'h22, 1'b1);
			chk("rd valid", 1'b1, rsp_valid);
			chk("rd no chan", 2'h0, chan_cmd_valid);
			chk("cml rd", 1'b1, cml_fault);
			wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
		end
		wr(CMD_PAGE, 16'h0000, 1'b0);
		wr(CMD_WRITE_PROTECT, 16'h0080, 1'b0);
		wr(CMD_GLOBAL_PAGE_MASK, 16'h0001, 1'b0);
		chk("wp1 mask", 2'h0, global_page_channel_mask);
		wr(CMD_WRITE_PROTECT, 16'h0040, 1'b0);
		chk("wp", 8'h40, write_protect_level);
		wr(CMD_GLOBAL_PAGE_MASK, 16'h0001, 1'b0);
		chk("wp2 mask", 2'h1, global_page_channel_mask);
		wr(CMD_WRITE_PROTECT, 16'h0000, 1'b0);
		wp_pin = 1'b1;
		wr(CMD_BUS_BASE_ADDRESS, 16'h0011, 1'b0);
		@(negedge clk);
		chk("pin base", 7'h5c, bus_address);
		wp_pin = 1'b0;
		wr(CMD_BUS_BASE_ADDRESS, 16'h0011, 1'b0);
		@(negedge clk);
		chk("base", 7'h11, bus_address);
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			{sel_h, sel_l, offs} = seed[5:0];
			repeat (2) @(negedge clk);
			chk("addr", exp_addr(7'h11, sel_h, sel_l, offs), bus_address);
		end
		for (int k = 0; k < 3; k++) begin
			seed = xs(seed);
			aux[k] = seed[15:0];
			wr(CMD_AUX_HOST_COMMAND + k[7:0], aux[k], 1'b0);
		end
		for (int k = 0; k < 3; k++) begin
			rd(CMD_AUX_HOST_COMMAND + k[7:0], 1'b0);
			chk("aux", aux[k], rsp_data);
		end
		stop_test();
	end
endmodule
